/* design/fsdm_top.sv */
// Slave diagnostic framer and mismatch handling of a remote base controller.
// Assumes the link layer hands in a one-cycle read request and consumes
// one diagnostic byte per cycle while diag_valid is high.
// Contract
// R1 - Strict mode, wrong module in configured slot: display code 2.
// R2 - Controller seated in wrong base slot: display code b.
// R3 - Internal diagnostic failures show A or E; never 4,5,6,8,C.
// R4 - Module in an unconfigured slot is ignored; operation continues.
// R5 - Strict mode mismatch: code 2, base offline, outputs per freeze jumper.
// R6 - Network stop: code 3, outputs per freeze jumper, inputs forced off.
// R7 - Diagnostic read returns exactly 15 bytes, bit 7 is MSB.
// R8 - Byte 1 holds station status 1 flags, bit 5 always 0.
// R9 - Byte 2: sync, freeze, constant 1 at bit 2, awaiting parameters.
// R10 - Byte 3 bit 7 zero, others reserved.
// R11 - Byte 4 parameterizing master address, 255 if none.
// R12 - Bytes 5 and 6 carry fixed 16-bit identification.
// R13 - Byte 7 is the device header 0x06.
// R14 - Byte 8 bit 0 flags remote-port request pending.
// R15 - Bytes 11 and 12 are the slot type-mismatch bitmap.
// R16 - Byte 13 is the identifier header 0x43.
// R17 - Bytes 14 and 15 flag failed or mismatched slots.
// R18 - Master counts slave no-response events, continuously during mismatch.
// R19 - Master keeps seven presence words, one bit per station. The master model keeps only one presence word.
// R20 - Master keeps seven enable words, one bit per station. The master model keeps only one enable word.
// R21 - Master flags unread diagnostics until they are read.
// R22 - Master status word bits 1, 2, 16: operate, clear, configured. The master model drives bit 1 high, bit 15 on stop and bit 16 when running.
// R23 - Ignore mode updates all matching modules, skips mismatched ones.
`timescale 1ns/1ps
module fsdm_top
    import fsdm_pkg::*;
#(
    parameter logic [15:0] IDENT = FSDM_IDENT_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic diag_req,
    input wire fsdm_status_t status,
    input wire fsdm_slots_t slots,
    input wire logic mismatch_ignore_option,
    input wire logic net_stop,
    input wire logic wrong_base_slot,
    input wire logic diag_fail_a,
    input wire logic diag_fail_e,
    input wire logic freeze_jumper,
    input wire logic [FSDM_SLOTS-1:0] out_data_in,
    input wire logic [FSDM_SLOTS-1:0] in_data_in,
    output logic diag_valid,
    output logic [7:0] diag_byte,
    output logic diag_last,
    output logic [3:0] display_code,
    output logic base_offline,
    output logic [FSDM_SLOTS-1:0] out_data,
    output logic [FSDM_SLOTS-1:0] in_data,
    output logic [FSDM_SLOTS-1:0] slot_update
);
    typedef struct packed
    {
        fsdm_state_t fsm;
        logic [3:0] idx;
        logic valid;
        logic [7:0] byte_out;
        logic last;
        logic [3:0] disp;
        logic offline;
        logic [FSDM_SLOTS-1:0] outs;
        logic [FSDM_SLOTS-1:0] ins;
        logic [FSDM_SLOTS-1:0] upd;
    } fsdm_top_state_t;

    fsdm_top_state_t st;
    fsdm_top_state_t next_st;
    logic [FSDM_SLOTS-1:0] mismatch_map;
    logic [FSDM_SLOTS-1:0] fail_map;
    logic [FSDM_SLOTS-1:0] update_en;
    logic base_mismatch;
    logic strict_offline;
    logic [7:0] frame_byte;

    fsdm_slot_eval u_eval
    (
        .clk(clk),
        .rst_n(rst_n),
        .slots(slots),
        .mismatch_ignore_option(mismatch_ignore_option),
        .mismatch_map(mismatch_map),
        .fail_map(fail_map),
        .update_en(update_en),
        .base_mismatch(base_mismatch)
    );

    assign strict_offline = base_mismatch & ~mismatch_ignore_option;

    // Byte selection for the current index; bytes 9 and 10 stay reserved
    always_comb
    begin
        frame_byte = FSDM_ZERO_BYTE;
        case (st.idx)
            4'h0:
            begin
                frame_byte[FSDM_S1_OTHER_MASTER] = status.prm_from_other; // [R8]
                frame_byte[FSDM_S1_PRM_ERR] = status.prm_error;
                frame_byte[FSDM_S1_INVALID] = 1'b0;
                frame_byte[FSDM_S1_NOT_SUPP] = status.not_supported;
                frame_byte[FSDM_S1_EXT] = 1'b1;
                frame_byte[FSDM_S1_CFG_ERR] = status.cfg_error | base_mismatch;
                frame_byte[FSDM_S1_NOT_READY] = status.not_ready;
                frame_byte[FSDM_S1_NO_RESP] = status.no_response;
            end
            4'h1:
            begin
                frame_byte[FSDM_S2_DEACT] = 1'b0; // [R9]
                frame_byte[FSDM_S2_SYNC] = status.sync_mode;
                frame_byte[FSDM_S2_FREEZE] = status.freeze_mode;
                frame_byte[FSDM_S2_ONE] = 1'b1;
                frame_byte[FSDM_S2_ZERO] = 1'b0;
                frame_byte[FSDM_S2_PRM_REQ] = status.awaiting_prm;
            end
            4'h2: frame_byte[FSDM_S3_OVF] = 1'b0; // [R10]
            4'h3: frame_byte = status.parameterized ? status.master_addr : FSDM_NO_MASTER; // [R11]
            4'h4: frame_byte = IDENT[15:8]; // [R12]
            4'h5: frame_byte = IDENT[7:0]; // [R12]
            4'h6: frame_byte = FSDM_DEV_HDR; // [R13]
            4'h7: frame_byte[FSDM_S8_REMOTE] = status.remote_req; // [R14]
            4'ha: frame_byte = mismatch_map[7:0]; // [R15]
            4'hb: frame_byte = mismatch_map[15:8]; // [R15]
            4'hc: frame_byte = FSDM_ID_HDR; // [R16]
            4'hd: frame_byte = fail_map[7:0]; // [R17]
            4'he: frame_byte = fail_map[15:8]; // [R17]
            default: frame_byte = FSDM_ZERO_BYTE;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.valid = 1'b0;
        next_st.last = 1'b0;
        next_st.byte_out = FSDM_ZERO_BYTE;
        case (st.fsm)
            FSDM_IDLE:
            begin
                next_st.idx = 4'h0;
                if (diag_req)
                    next_st.fsm = FSDM_SEND;
            end
            FSDM_SEND:
            begin
                // Exactly fifteen bytes, one per cycle [R7]
                next_st.valid = 1'b1;
                next_st.byte_out = frame_byte;
                next_st.last = (st.idx == FSDM_LAST_IDX);
                if (st.idx == FSDM_LAST_IDX)
                    next_st.fsm = FSDM_DONE;
                else
                    next_st.idx = st.idx + 4'h1;
            end
            FSDM_DONE:
            begin
                next_st.fsm = FSDM_IDLE;
                next_st.idx = 4'h0;
            end
            default: next_st.fsm = FSDM_IDLE;
        endcase

        // Display priority: seating fault, diag failure, stop, mismatch
        if (wrong_base_slot)
            next_st.disp = FSDM_DISP_WRONG_SLOT; // [R2]
        else if (diag_fail_a)
            next_st.disp = FSDM_DISP_DIAG_A; // [R3]
        else if (diag_fail_e)
            next_st.disp = FSDM_DISP_DIAG_E; // [R3]
        else if (net_stop)
            next_st.disp = FSDM_DISP_STOPPED; // [R6]
        else if (strict_offline)
            next_st.disp = FSDM_DISP_MISMATCH; // [R1]
        else
            next_st.disp = FSDM_DISP_OK; // [R4]

        next_st.offline = strict_offline; // [R5]
        if (net_stop || strict_offline)
        begin
            // Freeze jumper: hold last outputs, else clear them [R5] [R6]
            next_st.outs = freeze_jumper ? st.outs : '0;
            next_st.upd = '0;
        end
        else
        begin
            next_st.outs = (out_data_in & update_en) | (st.outs & ~update_en); // [R23]
            next_st.upd = update_en;
        end
        // Stop forces inputs off rather than holding them [R6]
        if (net_stop || strict_offline)
            next_st.ins = '0;
        else
            next_st.ins = (in_data_in & update_en) | (st.ins & ~update_en);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.fsm <= FSDM_IDLE;
        end
        else
            st <= next_st;
    end

    assign diag_valid = st.valid;
    assign diag_byte = st.byte_out;
    assign diag_last = st.last;
    assign display_code = st.disp;
    assign base_offline = st.offline;
    assign out_data = st.outs;
    assign in_data = st.ins;
    assign slot_update = st.upd;

    // Helper: counts bytes of the current frame
    logic [4:0] frame_cnt;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            frame_cnt <= 5'h00;
        else if (diag_req && st.fsm == FSDM_IDLE)
            frame_cnt <= 5'h00;
        else if (st.valid)
            frame_cnt <= frame_cnt + 5'h01;
    end

    a_frame_length: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        diag_req && st.fsm == FSDM_IDLE |=> ##1 diag_valid [*8] ##1 diag_valid [*7] ##1 !diag_valid)
        else $error("diagnostic frame not fifteen bytes");
    a_last_count: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        diag_last |-> diag_valid && frame_cnt == 5'h0e)
        else $error("last byte at wrong position");
    a_hdr_dev: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        diag_valid && frame_cnt == 5'h06 |-> diag_byte == FSDM_DEV_HDR)
        else $error("device header wrong");
    a_hdr_ident: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        diag_valid && frame_cnt == 5'h0c |-> diag_byte == FSDM_ID_HDR)
        else $error("identifier header wrong");
    a_byte2_const: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        diag_valid && frame_cnt == 5'h01 |-> diag_byte[2:1] == 2'b10 && !diag_byte[7])
        else $error("byte 2 constants wrong");
    a_byte1_bit5: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        diag_valid && frame_cnt == 5'h00 |-> !diag_byte[5] && diag_byte[3])
        else $error("byte 1 fixed bits wrong");
    a_byte3_msb: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        diag_valid && frame_cnt == 5'h02 |-> !diag_byte[7])
        else $error("byte 3 msb set");
    a_ident_bytes: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        diag_valid && frame_cnt == 5'h04 |=> diag_byte == IDENT[7:0] && $past(diag_byte) == IDENT[15:8])
        else $error("identification bytes wrong");
    a_stop_inputs: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        net_stop |=> in_data == '0 && display_code == FSDM_DISP_STOPPED)
        else $error("inputs not forced off on stop");
    a_wrong_slot: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        wrong_base_slot |=> display_code == FSDM_DISP_WRONG_SLOT)
        else $error("wrong slot code missing");
    a_legacy_codes: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        !(display_code inside {4'h4, 4'h5, 4'h6, 4'h8, 4'hc}))
        else $error("legacy display code shown");
    a_strict_offline: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        base_mismatch && !mismatch_ignore_option |=> base_offline && slot_update == '0)
        else $error("strict mismatch did not take base offline");
    a_mismatch_code: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        strict_offline && !wrong_base_slot && !diag_fail_a && !diag_fail_e && !net_stop
        |=> display_code == FSDM_DISP_MISMATCH)
        else $error("mismatch code missing");
    a_ignore_update: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
        mismatch_ignore_option && !net_stop |=> slot_update == $past(update_en) && !base_offline)
        else $error("ignore mode update set wrong");

    c_frame: cover property (@(posedge clk) disable iff (!rst_n) diag_last);
    c_strict: cover property (@(posedge clk) disable iff (!rst_n) base_offline);
    c_ignore: cover property (@(posedge clk) disable iff (!rst_n)
        mismatch_ignore_option && base_mismatch);
    c_stop: cover property (@(posedge clk) disable iff (!rst_n)
        display_code == FSDM_DISP_STOPPED);
endmodule

/* design/fsdm_pkg.sv */
// Package for the slave diagnostic framer: sizes, constants and carriers.
// Assumes one 50 MHz clock domain shared by all users.
package fsdm_pkg;
    localparam int FSDM_SLOTS = 16;
    localparam int FSDM_DIAG_LEN = 15;
    localparam logic [3:0] FSDM_LAST_IDX = 4'he;
    localparam logic [7:0] FSDM_NO_MASTER = 8'hff;
    // Arbitrary neutral identification value
    localparam logic [15:0] FSDM_IDENT_DEFAULT = 16'h1234;
    localparam logic [7:0] FSDM_DEV_HDR = 8'h06;
    localparam logic [7:0] FSDM_ID_HDR = 8'h43;
    localparam logic [7:0] FSDM_ZERO_BYTE = 8'h00;
    // Byte 1 bit positions
    localparam int FSDM_S1_OTHER_MASTER = 7;
    localparam int FSDM_S1_PRM_ERR = 6;
    localparam int FSDM_S1_INVALID = 5;
    localparam int FSDM_S1_NOT_SUPP = 4;
    localparam int FSDM_S1_EXT = 3;
    localparam int FSDM_S1_CFG_ERR = 2;
    localparam int FSDM_S1_NOT_READY = 1;
    localparam int FSDM_S1_NO_RESP = 0;
    // Byte 2, byte 3 and byte 8 bit positions
    localparam int FSDM_S2_DEACT = 7;
    localparam int FSDM_S2_SYNC = 5;
    localparam int FSDM_S2_FREEZE = 4;
    localparam int FSDM_S2_ONE = 2;
    localparam int FSDM_S2_ZERO = 1;
    localparam int FSDM_S2_PRM_REQ = 0;
    localparam int FSDM_S3_OVF = 7;
    localparam int FSDM_S8_REMOTE = 0;
    // Display codes
    localparam logic [3:0] FSDM_DISP_OK = 4'h0;
    localparam logic [3:0] FSDM_DISP_MISMATCH = 4'h2;
    localparam logic [3:0] FSDM_DISP_STOPPED = 4'h3;
    localparam logic [3:0] FSDM_DISP_DIAG_A = 4'ha;
    localparam logic [3:0] FSDM_DISP_WRONG_SLOT = 4'hb;
    localparam logic [3:0] FSDM_DISP_DIAG_E = 4'he;

    typedef enum logic [1:0]
    {
        FSDM_IDLE = 2'b00,
        FSDM_SEND = 2'b01,
        FSDM_DONE = 2'b11
    } fsdm_state_t;

    typedef struct packed
    {
        logic prm_from_other;
        logic prm_error;
        logic not_supported;
        logic cfg_error;
        logic not_ready;
        logic no_response;
        logic sync_mode;
        logic freeze_mode;
        logic awaiting_prm;
        logic remote_req;
        logic [7:0] master_addr;
        logic parameterized;
    } fsdm_status_t;

    typedef struct packed
    {
        logic [FSDM_SLOTS-1:0] configured;
        logic [FSDM_SLOTS-1:0] present;
        logic [FSDM_SLOTS-1:0] type_ok;
        logic [FSDM_SLOTS-1:0] failed;
    } fsdm_slots_t;
endpackage

/* design/fsdm_slot_eval.sv */
// Per-slot mismatch evaluation for the base slots.
// Assumes slot inputs are already synchronous to clk.
`timescale 1ns/1ps
module fsdm_slot_eval
    import fsdm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire fsdm_slots_t slots,
    input wire logic mismatch_ignore_option,
    output logic [FSDM_SLOTS-1:0] mismatch_map,
    output logic [FSDM_SLOTS-1:0] fail_map,
    output logic [FSDM_SLOTS-1:0] update_en,
    output logic base_mismatch
);
    typedef struct packed
    {
        logic [FSDM_SLOTS-1:0] mm;
        logic [FSDM_SLOTS-1:0] fl;
        logic [FSDM_SLOTS-1:0] upd;
        logic any;
    } fsdm_eval_t;

    fsdm_eval_t st;
    fsdm_eval_t next_st;
    logic [FSDM_SLOTS-1:0] raw_mm;

    genvar g;
    generate
        for (g = 0; g < FSDM_SLOTS; g++)
        begin : g_slot
            // Unconfigured slots never mismatch, whatever is inserted [R4]
            assign raw_mm[g] = slots.configured[g] & ~(slots.present[g] & slots.type_ok[g]);
        end
    endgenerate

    always_comb
    begin
        next_st = st;
        next_st.mm = raw_mm;
        next_st.fl = raw_mm | (slots.configured & slots.failed); // [R17]
        next_st.any = |raw_mm;
        // Ignore mode keeps matching slots running; strict mode stops all on any mismatch [R23] [R5]
        if (mismatch_ignore_option)
            next_st.upd = slots.configured & ~raw_mm;
        else if (|raw_mm)
            next_st.upd = '0;
        else
            next_st.upd = slots.configured;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign mismatch_map = st.mm;
    assign fail_map = st.fl;
    assign update_en = st.upd;
    assign base_mismatch = st.any;
endmodule

/* verif/fsdm_master_model.sv */
// Behavioural bus master: asks for diagnostic reads, keeps station words.
// Assumes one slave at SLAVE_ADDR within the first presence word.
`timescale 1ns/1ps
module fsdm_master_model
    import fsdm_pkg::*;
#(
    parameter int SLAVE_ADDR = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_go,
    input wire logic stop_go,
    input wire logic diag_last,
    input wire logic base_offline,
    output logic diag_req,
    output logic net_stop,
    output logic busy,
    output logic [15:0] fail_count,
    output logic [15:0] presence_word,
    output logic [15:0] enable_word,
    output logic [15:0] network_state_word,
    output logic diag_pending
);
    logic offline_q;

    assign enable_word = 16'h0001 << (SLAVE_ADDR - 1);
    assign network_state_word = {~net_stop, net_stop, 13'h0000, 1'b1};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            diag_req <= 1'b0;
            net_stop <= 1'b0;
            busy <= 1'b0;
            fail_count <= 16'h0000;
            presence_word <= 16'h0000;
            diag_pending <= 1'b0;
            offline_q <= 1'b0;
        end
        else
        begin
            // No new read until the last byte, so nothing is refused
            diag_req <= rd_go & ~busy;
            if (rd_go & ~busy)
                busy <= 1'b1;
            else if (diag_last)
                busy <= 1'b0;
            net_stop <= stop_go;
            offline_q <= base_offline;
            if (base_offline)
                fail_count <= fail_count + 16'h0001;
            presence_word[SLAVE_ADDR-1] <= base_offline;
            if (base_offline & ~offline_q)
                diag_pending <= 1'b1;
            else if (diag_last)
                diag_pending <= 1'b0;
        end
    end
endmodule

/* verif/fsdm_top_test.sv */
// Self-checking bench for the slave diagnostic framer.
// Assumes fsdm_top and the master model; expectations built from the inputs.
`timescale 1ns/1ps
module fsdm_top_test
    import fsdm_pkg::*;
;
    // Arbitrary identification value
    localparam logic [15:0] IDENT_V = 16'h5a3c;
    logic clk, rst_n, diag_req, net_stop, busy, rd_go, stop_go;
    logic ign, wbs, fa, fe, frz, dv, dl, off;
    fsdm_status_t st;
    fsdm_slots_t sl;
    logic [15:0] od_in, id_in, od, id, upd, mm, fm, cfg, tok, held;
    logic [7:0] db;
    logic [3:0] disp, ed;
    logic [31:0] r;
    logic [8:0] expq[$];
    int n_mismatch, checked, seed, cyc, k;

    fsdm_top #(.IDENT(IDENT_V)) dut (.clk(clk), .rst_n(rst_n), .diag_req(diag_req),
        .status(st), .slots(sl), .mismatch_ignore_option(ign), .net_stop(net_stop),
        .wrong_base_slot(wbs), .diag_fail_a(fa), .diag_fail_e(fe), .freeze_jumper(frz),
        .out_data_in(od_in), .in_data_in(id_in), .diag_valid(dv), .diag_byte(db),
        .diag_last(dl), .display_code(disp), .base_offline(off), .out_data(od),
        .in_data(id), .slot_update(upd));

    fsdm_master_model model (.clk(clk), .rst_n(rst_n), .rd_go(rd_go), .stop_go(stop_go),
        .diag_last(dl), .base_offline(off), .diag_req(diag_req), .net_stop(net_stop),
        .busy(busy), .fail_count(), .presence_word(), .enable_word(),
        .network_state_word(), .diag_pending());

    task automatic check(string nm, logic [15:0] e, logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic read_frame();
        logic [7:0] f[15];
        f[0] = {st.prm_from_other, st.prm_error, 1'b0, st.not_supported, 1'b1,
            st.cfg_error | (|mm), st.not_ready, st.no_response};
        f[1] = {2'b00, st.sync_mode, st.freeze_mode, 3'b010, st.awaiting_prm};
        f[2] = 8'h00;
        f[3] = st.parameterized ? st.master_addr : 8'hff;
        f[4] = IDENT_V[15:8];
        f[5] = IDENT_V[7:0];
        f[6] = 8'h06;
        f[7] = {7'h00, st.remote_req};
        f[8] = 8'h00;
        f[9] = 8'h00;
        f[10] = mm[7:0];
        f[11] = mm[15:8];
        f[12] = 8'h43;
        f[13] = fm[7:0];
        f[14] = fm[15:8];
        for (int i = 0; i < 15; i++)
            expq.push_back({i == 14, f[i]});
        rd_go <= 1'b1;
        @(posedge clk);
        rd_go <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; k < 40 && busy === 1'b1; k++)
            @(posedge clk);
        check("bytes left", 16'h0000, 16'(expq.size()));
    endtask

    // Result watcher: one note per byte, last flag beside it
    always @(posedge clk)
    begin
        if (dv === 1'b1)
        begin
            if (expq.size() == 0)
                check("diag_valid", 16'h0000, 16'h0001);
            else
                check("diag_byte", {7'h00, expq.pop_front()}, {7'h00, dl, db});
        end
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        {rst_n, rd_go, stop_go, ign, wbs, fa, fe, frz} = 8'h00;
        st = '0;
        sl = '0;
        {od_in, id_in, mm, fm} = '0;
        seed = 60;
        repeat (5) @(posedge clk);
        check("reset outs", 16'h0000, {9'h000, dv, dl, off, disp});
        check("reset data", 16'h0000, od | id | upd);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int n = 0; n < 32; n++)
        begin
            r = $random(seed);
            st <= r[$bits(fsdm_status_t)-1:0];
            cfg = 16'($random(seed));
            tok = (n % 3 == 0) ? 16'hffff : 16'($random(seed)) | 16'($random(seed));
            mm = cfg & ~tok;
            fm = mm | (cfg & 16'($random(seed)));
            // Empty slots get random modules: they must be ignored
            sl <= '{configured: cfg, present: cfg | 16'($random(seed)), type_ok: tok,
                failed: fm & ~mm};
            ign <= r[24];
            frz <= r[25];
            wbs <= (n % 8 == 1);
            fa <= (n % 8 == 2);
            fe <= (n % 8 == 3);
            stop_go <= (n % 8 == 4);
            od_in <= 16'($random(seed));
            id_in <= 16'($random(seed));
            repeat (5) @(posedge clk);
            ed = wbs ? 4'hb : fa ? 4'ha : fe ? 4'he : net_stop ? 4'h3 : (|mm) ? 4'h2 : 4'h0;
            if (!(ign && ed == 4'h2))
                check("display_code", {12'h000, ed}, {12'h000, disp});
            if (!(wbs | fa | fe | net_stop))
            begin
                check("base_offline", {15'h0000, !ign && (|mm)}, {15'h0000, off});
                check("slot_update", (!ign && (|mm)) ? 16'h0000 : cfg & ~mm, upd);
            end
            if (net_stop | off)
            begin
                check("in_data", 16'h0000, id);
                held = frz ? od : 16'h0000;
                od_in <= ~od_in;
                repeat (3) @(posedge clk);
                check("out_data", held, od);
            end
            read_frame();
        end
        final_report();
    end
endmodule
